// File: design/tec_cfg.svh
// register map, field positions and reset values for the timer/event counter set
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH
`define TEC_ADR_C0_LOW 3'h0
`define TEC_ADR_C0_HIGH 3'h1
`define TEC_ADR_C1_VALUE 3'h2
`define TEC_ADR_C2_VALUE 3'h3
`define TEC_ADR_C0_CTRL 3'h4
`define TEC_ADR_C1_CTRL 3'h5
`define TEC_ADR_C2_CTRL 3'h6
`define TEC_ADR_IRQ 3'h7
`define TEC_MODE_HI 7
`define TEC_MODE_LO 6
`define TEC_CLKSEL 5
`define TEC_RUN 4
`define TEC_EDGE 3
`define TEC_PSC_HI 2
`define TEC_PSC_LO 0
`define TEC_MODE_EVENT 2'h1
`define TEC_MODE_TIMER 2'h2
`define TEC_MODE_PULSE 2'h3
`define TEC_CTRL_RST 8'h00
`define TEC_CNT_RST 16'h0000
`define TEC_DIV8_LAST 3'h7
`define TEC_ALL_ONES8 8'hFF
`define TEC_ALL_ONES16 16'hFFFF
`endif

// File: design/tec_pkg.sv
// types shared by the timer/event counter set
package tec_pkg;
	// one counter's state
	typedef struct packed {
		logic [7:0] ctrl;
		logic [15:0] preload;
		logic [15:0] count;
		logic [6:0] psc;
		logic pin_d;
		logic tick_d;
		logic ovf;
	} tec_cnt_t;
	// whole block state
	typedef struct packed {
		tec_cnt_t c0;
		tec_cnt_t c1;
		tec_cnt_t c2;
		logic [7:0] low_buf;
		logic [2:0] div8;
		logic [1:0] rc_s;
		logic [1:0] ev0_s;
		logic [1:0] ev1_s;
		logic [2:0] irq_en;
		logic [2:0] irq_req;
		logic wake;
		logic irq;
		logic ack;
		logic [31:0] dat;
	} tec_state_t;
endpackage

// File: design/tec_top.sv
// three count-up counters behind a classic wishbone slave: counter0 and counter1 timer/event, counter2 timer only
`include "tec_cfg.svh"

module tec_top
(
	// system
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [4:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// timing sources and pins
	input wire logic slow_rc_clock_i,
	input wire logic event_input_a_i,
	input wire logic event_input_b_i,
	// requests out
	output logic irq_o,
	output logic wake_o
);
	tec_pkg::tec_state_t s; // registered state
	tec_pkg::tec_state_t next_s; // next state

	// one counter's step; width 16 or 8 chosen by wide
	function automatic tec_pkg::tec_cnt_t step(input tec_pkg::tec_cnt_t c, input logic wide,
		input logic has_ext, input logic clk_lvl, input logic pin, input logic hold,
		output logic ovf_ev, output logic ext_ovf);
		tec_pkg::tec_cnt_t n;
		logic [1:0] mode;
		logic pin_act;
		logic prev_act;
		logic fall;
		logic pin_edge;
		logic inc;
		logic full;
		n = c;
		ovf_ev = 1'b0;
		ext_ovf = 1'b0;
		mode = c.ctrl[`TEC_MODE_HI:`TEC_MODE_LO];
		if (!has_ext)
			mode = `TEC_MODE_TIMER;
		// pulse mode with edge bit low waits for a falling start, so its active level is inverted
		pin_act = pin ^ c.ctrl[`TEC_EDGE] ^ (mode == `TEC_MODE_PULSE);
		// the raw pin is kept, so changing the edge bit cannot fake an edge
		prev_act = c.pin_d ^ c.ctrl[`TEC_EDGE] ^ (mode == `TEC_MODE_PULSE);
		pin_edge = pin_act & ~prev_act;
		fall = c.tick_d & ~clk_lvl;
		n.tick_d = clk_lvl;
		n.pin_d = pin;
		inc = 1'b0;
		unique case (mode)
			`TEC_MODE_EVENT: inc = pin_edge;
			`TEC_MODE_PULSE: inc = fall & pin_act;
			default: inc = fall;
		endcase
		// pulse end: pin back to idle level stops and clears run
		if (mode == `TEC_MODE_PULSE && c.ctrl[`TEC_RUN] && prev_act && !pin_act)
		begin
			n.ctrl[`TEC_RUN] = 1'b0;
			inc = 1'b0;
		end
		full = wide ? (c.count == `TEC_ALL_ONES16) : (c.count[7:0] == `TEC_ALL_ONES8);
		if (c.ctrl[`TEC_RUN] && inc && !hold)
		begin
			if (full)
			begin
				n.count = c.preload;
				ovf_ev = 1'b1;
				ext_ovf = (mode == `TEC_MODE_EVENT);
			end
			else
				n.count = wide ? c.count + 16'h0001 : {8'h00, c.count[7:0] + 8'h01};
		end
		return n;
	endfunction

	// prescaler output bit for a 3-bit ratio field
	function automatic logic psc_bit(input tec_pkg::tec_cnt_t c);
		logic [7:0] taps;
		// ratio code zero has no tap: the clock itself is never used as data
		taps = {c.psc, 1'b0};
		return taps[c.ctrl[`TEC_PSC_HI:`TEC_PSC_LO]];
	endfunction

	logic wr; // write strobe this cycle
	logic rd; // read strobe this cycle
	logic [2:0] reg_idx; // word index
	logic [7:0] wbyte; // low write byte
	logic o0; // overflow events
	logic o1;
	logic o2;
	logic e0; // event-mode overflows
	logic e1;
	logic e2;
	logic c0_clk; // counter0 count clock level
	logic [7:0] rdat; // read mux

	assign reg_idx = adr_i[4:2];
	assign wbyte = sel_i[0] ? dat_i[7:0] : 8'h00;

	// next-state logic: counting, bus access, requests
	always_comb
	begin
		next_s = s;
		// strobe only once per request; ack high means served
		wr = cyc_i & stb_i & we_i & ~s.ack;
		rd = cyc_i & stb_i & ~we_i & ~s.ack;
		next_s.ack = cyc_i & stb_i & ~s.ack;
		// free-running dividers; internal clock levels from counter bits
		next_s.div8 = s.div8 + 3'h1;
		next_s.c1.psc = s.c1.psc + 7'h01;
		next_s.c2.psc = s.c2.psc + 7'h01;
		// pin synchronisers
		next_s.rc_s = {s.rc_s[0], slow_rc_clock_i};
		next_s.ev0_s = {s.ev0_s[0], event_input_a_i};
		next_s.ev1_s = {s.ev1_s[0], event_input_b_i};
		c0_clk = s.c0.ctrl[`TEC_CLKSEL] ? s.rc_s[1] : s.div8[2];
		// counting; a read of the counter holds it for that access
		next_s.c0 = step(s.c0, 1'b1, 1'b1, c0_clk, s.ev0_s[1],
			rd && (reg_idx == `TEC_ADR_C0_LOW || reg_idx == `TEC_ADR_C0_HIGH), o0, e0);
		next_s.c1 = step(s.c1, 1'b0, 1'b1, psc_bit(s.c1), s.ev1_s[1],
			rd && reg_idx == `TEC_ADR_C1_VALUE, o1, e1);
		next_s.c2 = step(s.c2, 1'b0, 1'b0, psc_bit(s.c2), 1'b0,
			rd && reg_idx == `TEC_ADR_C2_VALUE, o2, e2);
		next_s.c1.psc = s.c1.psc + 7'h01;
		next_s.c2.psc = s.c2.psc + 7'h01;
		next_s.c0.psc = 7'h00;
		// read data; high read latches current low count
		rdat = 8'h00;
		unique case (reg_idx)
			`TEC_ADR_C0_LOW: rdat = s.low_buf;
			`TEC_ADR_C0_HIGH: rdat = s.c0.count[15:8];
			`TEC_ADR_C1_VALUE: rdat = s.c1.count[7:0];
			`TEC_ADR_C2_VALUE: rdat = s.c2.count[7:0];
			`TEC_ADR_C0_CTRL: rdat = s.c0.ctrl;
			`TEC_ADR_C1_CTRL: rdat = s.c1.ctrl;
			`TEC_ADR_C2_CTRL: rdat = s.c2.ctrl;
			default: rdat = {2'h0, s.irq_req, s.irq_en};
		endcase
		if (rd)
			next_s.dat = {24'h000000, rdat};
		if (rd && reg_idx == `TEC_ADR_C0_HIGH)
			next_s.low_buf = s.c0.count[7:0];
		// writes; preload loads the counter only while stopped
		if (wr && sel_i[0])
		begin
			unique case (reg_idx)
				`TEC_ADR_C0_LOW: next_s.low_buf = wbyte;
				`TEC_ADR_C0_HIGH:
				begin
					next_s.c0.preload = {wbyte, s.low_buf};
					if (!s.c0.ctrl[`TEC_RUN])
						next_s.c0.count = {wbyte, s.low_buf};
				end
				`TEC_ADR_C1_VALUE:
				begin
					next_s.c1.preload = {8'h00, wbyte};
					if (!s.c1.ctrl[`TEC_RUN])
						next_s.c1.count = {8'h00, wbyte};
				end
				`TEC_ADR_C2_VALUE:
				begin
					next_s.c2.preload = {8'h00, wbyte};
					if (!s.c2.ctrl[`TEC_RUN])
						next_s.c2.count = {8'h00, wbyte};
				end
				`TEC_ADR_C0_CTRL: next_s.c0.ctrl = wbyte;
				`TEC_ADR_C1_CTRL: next_s.c1.ctrl = wbyte;
				`TEC_ADR_C2_CTRL: next_s.c2.ctrl = wbyte;
				default:
				begin
					next_s.irq_en = wbyte[2:0];
					// write one clears a request; a new overflow wins below
					next_s.irq_req = s.irq_req & ~wbyte[5:3];
				end
			endcase
		end
		// overflow sets requests; set beats clear
		next_s.irq_req = next_s.irq_req | {o2, o1, o0};
		next_s.c0.ovf = o0;
		next_s.c1.ovf = o1;
		next_s.c2.ovf = o2;
		next_s.irq = |(next_s.irq_req & next_s.irq_en);
		next_s.wake = o0 | o1 | o2 | e0 | e1 | e2;
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s <= '0;
			s.c0.ctrl <= `TEC_CTRL_RST;
			s.c0.count <= `TEC_CNT_RST;
		end
		else
			s <= next_s;
	end

	// outputs straight from flops
	assign dat_o = s.dat;
	assign ack_o = s.ack;
	assign irq_o = s.irq;
	assign wake_o = s.wake;
endmodule

// File: verification/tec_top_monitor.sv
// checker of bus handshake and request outputs of the counter set
module tec_top_monitor
(
	// watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic irq_o,
	input wire logic wake_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a request the slave takes
	sequence s_take;
		cyc_i && stb_i && !ack_o;
	endsequence
	a_ack_next: assert property (s_take |=> ack_o) else $error("no ack");
	a_ack_once: assert property (ack_o |=> !ack_o) else $error("long ack");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
	a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("idle ack");
	a_rd_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0) else $error("upper bits");
	a_wake_once: assert property (wake_o |=> !wake_o) else $error("long wake");
	a_req_reset: assert property ($fell(rst_i) |-> !irq_o && !wake_o) else $error("reset req");
	// the request line moves only on an overflow or a register access
	a_irq_cause: assert property ($changed(irq_o) |-> wake_o || $past(wake_o) || ack_o || $past(ack_o))
		else $error("irq moved alone");
endmodule

// File: verification/tec_pin_model.sv
// model of the event pins and the free running slow oscillator
module tec_pin_model
(
	// clock
	input wire logic clk_i,
	// pins
	output logic pin_a_o,
	output logic pin_b_o,
	output logic rc_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		pin_a_o = 1'b0;
		pin_b_o = 1'b0;
		rc_o = 1'b0;
	end
	// oscillator runs free and far slower than clk_i
	always
	begin
		repeat (8) @(posedge clk_i);
		rc_o <= ~rc_o;
	end
	// one pulse from idle low; w outlasts the synchroniser delay
	task pulse(input logic b, input int w);
		@(posedge clk_i);
		if (b)
			pin_b_o <= 1'b1;
		else
			pin_a_o <= 1'b1;
		repeat (w) @(posedge clk_i);
		pin_a_o <= 1'b0;
		pin_b_o <= 1'b0;
		repeat (w) @(posedge clk_i);
	endtask
endmodule

// File: verification/tec_top_bench.sv
// self-checking bench of the counter set
`include "tec_cfg.svh"
module tec_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [4:0] adr_i = 5'h00;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o, q;
	logic ack_o, irq_o, wake_o, rc, pa, pb;
	int fail_count = 0;
	int n_compared = 0;
	int wakes = 0;
	always #50 clk_i = ~clk_i;
	// wake is a one-cycle pulse, so count it at every edge
	always @(posedge clk_i)
		if (wake_o === 1'b1)
			wakes++;
	tec_pin_model pins(.clk_i(clk_i), .pin_a_o(pa), .pin_b_o(pb), .rc_o(rc));
	tec_top dut(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(4'h1),
		.adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .slow_rc_clock_i(rc),
		.event_input_a_i(pa), .event_input_b_i(pb), .irq_o(irq_o), .wake_o(wake_o));
	task wrap_up;
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle, ack awaited under a bound
	task wb(input logic [2:0] a, input logic w, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {a, 2'h0};
		dat_i <= {24'h0, d};
		do
			@(posedge clk_i);
		while (ack_o !== 1'b1 && k++ < 20);
		if (k >= 20)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, ack_o, 1'b1);
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		wb(a, 1'b0, 8'h00);
		chk(q, {24'h0, e});
	endtask
	// every word reads zero after reset
	task t_reset;
		for (int i = 0; i < 8; i++)
			rd(3'(i), 8'h00);
	endtask
	// buffered 16-bit access while stopped
	task t_pair;
		wb(`TEC_ADR_C0_LOW, 1'b1, 8'h34);
		rd(`TEC_ADR_C0_HIGH, 8'h00);
		rd(`TEC_ADR_C0_LOW, 8'h00);
		wb(`TEC_ADR_C0_LOW, 1'b1, 8'h34);
		wb(`TEC_ADR_C0_HIGH, 1'b1, 8'h12);
		rd(`TEC_ADR_C0_HIGH, 8'h12);
		rd(`TEC_ADR_C0_LOW, 8'h34);
	endtask
	// counter2 asked for event mode still times and requests
	task t_timer;
		wb(`TEC_ADR_C2_VALUE, 1'b1, 8'hFE);
		wb(`TEC_ADR_IRQ, 1'b1, 8'h04);
		wakes = 0;
		wb(`TEC_ADR_C2_CTRL, 1'b1, 8'h51);
		repeat (40) @(posedge clk_i);
		chk(wakes != 0, 1);
		chk(irq_o, 1);
		wb(`TEC_ADR_C2_CTRL, 1'b1, 8'h41);
		rd(`TEC_ADR_IRQ, 8'h24);
		wb(`TEC_ADR_IRQ, 1'b1, 8'h20);
		rd(`TEC_ADR_IRQ, 8'h00);
	endtask
	// counter1 event counting, edge choice, preload while running
	task t_event;
		wb(`TEC_ADR_C1_VALUE, 1'b1, 8'hFD);
		wb(`TEC_ADR_C1_CTRL, 1'b1, 8'h50);
		wakes = 0;
		repeat (2) pins.pulse(1'b1, 6);
		rd(`TEC_ADR_C1_VALUE, 8'hFF);
		chk(wakes, 0);
		pins.pulse(1'b1, 6);
		chk(wakes, 1);
		chk(irq_o, 0);
		rd(`TEC_ADR_C1_VALUE, 8'hFD);
		wb(`TEC_ADR_C1_CTRL, 1'b1, 8'h58);
		wb(`TEC_ADR_C1_VALUE, 1'b1, 8'h10);
		pins.pulse(1'b1, 6);
		rd(`TEC_ADR_C1_VALUE, 8'hFE);
		repeat (2) pins.pulse(1'b1, 6);
		rd(`TEC_ADR_C1_VALUE, 8'h10);
	endtask
	// 64 clocks of active pin give about eight div8 counts
	task t_pulse;
		wb(`TEC_ADR_C0_LOW, 1'b1, 8'h00);
		wb(`TEC_ADR_C0_HIGH, 1'b1, 8'h00);
		wb(`TEC_ADR_C0_CTRL, 1'b1, 8'hD8);
		pins.pulse(1'b0, 64);
		rd(`TEC_ADR_C0_CTRL, 8'hC8);
		rd(`TEC_ADR_C0_HIGH, 8'h00);
		wb(`TEC_ADR_C0_LOW, 1'b0, 8'h00);
		chk(q > 6 && q < 10, 1);
	endtask
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_pair;
		t_timer;
		t_event;
		t_pulse;
		wrap_up;
	end
	// watchdog well past the few hundred cycles needed
	initial
	begin
		#3000000;
		fail_count++;
		wrap_up;
	end
endmodule
bind tec_top tec_top_monitor mon(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .wake_o(wake_o));
